/* include/sep_pkg.sv */
// Constants for the serial EEPROM command and protection core
package sep_pkg;
  localparam int ADDR_W = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_BITS = 7;
  // Opcodes with bit 3 masked off
  localparam logic [7:0] OP_MASK = 8'hf7;
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_ARRAY = 8'h03;
  localparam logic [7:0] OP_WR_ARRAY = 8'h02;
  // Status byte fields
  localparam int ST_PPEN = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam logic [7:0] ST_BUSY_VALUE = 8'hff;
  // Protection range starts
  localparam logic [15:0] PROT_QUARTER = 16'hc000;
  localparam logic [15:0] PROT_HALF = 16'h8000;
  localparam logic [15:0] PROT_ALL = 16'h0000;
  // Reset values of the nonvolatile bits
  localparam logic RST_PPEN = 1'b0;
  localparam logic [1:0] RST_BP = 2'h0;
  // Self-timed write cycle
  localparam int WRITE_CYCLE_MS = 5;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {
    SEP_OPCODE, SEP_ADDR, SEP_READ, SEP_STATUS_RD, SEP_STATUS_WR, SEP_WRITE, SEP_IGNORE
  } sep_state_t;
endpackage

/* rtl/sep_core.sv */
// SPI mode 0 serial EEPROM slave: commands, protection, page write
`timescale 1ns/1ps
module sep_core #(
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLE_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Protect pin
  input wire logic wp_b_i,
  // Status observation
  output logic busy_o,
  output logic write_latch_o
);
  import sep_pkg::*;

  // Pin synchronisers
  // Reset to idle pin levels so no false edge follows release
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] sdi_s;
  logic [1:0] wp_s;
  logic sclk_d;
  logic cs_d;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      sdi_s <= 2'h0;
      wp_s <= 2'h3;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      cs_s <= {cs_s[0], cs_b_i};
      sdi_s <= {sdi_s[0], sdi_i};
      wp_s <= {wp_s[0], wp_b_i};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;
  logic sdi;
  logic wp_low;
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign cs_fall = ~cs_s[1] & cs_d;
  assign cs_rise = cs_s[1] & ~cs_d;
  assign selected = ~cs_s[1] & ~cs_d;
  assign sdi = sdi_s[1];
  assign wp_low = ~wp_s[1];

  // Nonvolatile status bits and array
  logic ppen;
  logic [1:0] bp;
  logic wel;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld;

  logic hw_prot;
  assign hw_prot = wp_low & ppen;

  function automatic logic addr_protected(input logic [15:0] a, input logic [1:0] lvl);
    unique case (lvl)
      2'h0: addr_protected = 1'b0;
      2'h1: addr_protected = (a >= PROT_QUARTER);
      2'h2: addr_protected = (a >= PROT_HALF);
      default: addr_protected = (a >= PROT_ALL);
    endcase
  endfunction

  // Serial front end
  sep_state_t state;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [15:0] addr;
  logic [3:0] addr_bytes;
  logic [7:0] opcode;
  logic [7:0] tx;
  logic [7:0] status_wr_val;
  logic status_wr_pend, array_wr_pend;
  logic busy;
  logic [31:0] wcnt;
  logic wr_sr_cycle;
  logic [7:0] status_byte;
  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = selected & sclk_rise & (bitcnt == 3'h7);
  assign rx_byte = {shreg[6:0], sdi};
  assign status_byte = busy ? ST_BUSY_VALUE : {ppen, 3'h0, bp, wel, 1'b0};

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
    end else if (!selected) begin
      bitcnt <= 3'h0;
    end else if (sclk_rise) begin
      shreg <= rx_byte;
      bitcnt <= bitcnt + 3'h1;
    end
  end

  // Command sequencer
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state <= SEP_OPCODE;
      opcode <= 8'h00;
      addr <= 16'h0000;
      addr_bytes <= 4'h0;
      tx <= 8'h00;
      status_wr_pend <= 1'b0;
      array_wr_pend <= 1'b0;
      status_wr_val <= 8'h00;
      page_vld <= '0;
    end else if (cs_fall) begin
      state <= SEP_OPCODE;
      addr_bytes <= 4'h0;
      status_wr_pend <= 1'b0;
      array_wr_pend <= 1'b0;
      // Keep the page while a running write cycle still commits it
      page_vld <= busy ? page_vld : '0;
    end else if (cs_rise) begin
      state <= SEP_IGNORE;
      status_wr_pend <= 1'b0;
      array_wr_pend <= 1'b0;
    end else if (byte_done) begin
      unique case (state)
        SEP_OPCODE: begin
          opcode <= rx_byte & OP_MASK;
          if (busy && (rx_byte & OP_MASK) != OP_RD_STATUS) begin
            state <= SEP_IGNORE;
          end else begin
            unique case (rx_byte & OP_MASK)
              OP_RD_STATUS: begin
                state <= SEP_STATUS_RD;
                tx <= status_byte;
              end
              OP_WR_STATUS: state <= (wel && !hw_prot) ? SEP_STATUS_WR : SEP_IGNORE;
              OP_RD_ARRAY: state <= SEP_ADDR;
              OP_WR_ARRAY: state <= wel ? SEP_ADDR : SEP_IGNORE;
              default: state <= SEP_IGNORE;
            endcase
          end
        end
        SEP_ADDR: begin
          addr <= {addr[7:0], rx_byte};
          addr_bytes <= addr_bytes + 4'h1;
          if (addr_bytes == 4'h1) begin
            if (opcode == OP_RD_ARRAY) begin
              state <= SEP_READ;
              tx <= mem[{addr[7:0], rx_byte}];
            end else begin
              state <= SEP_WRITE;
            end
          end
        end
        SEP_READ: begin
          addr <= addr + 16'h0001;
          tx <= mem[addr + 16'h0001];
        end
        SEP_STATUS_RD: tx <= status_byte;
        SEP_STATUS_WR: begin
          status_wr_val <= rx_byte;
          status_wr_pend <= 1'b1;
          state <= SEP_IGNORE;
        end
        SEP_WRITE: begin
          page_buf[addr[PAGE_BITS-1:0]] <= rx_byte;
          page_vld[addr[PAGE_BITS-1:0]] <= 1'b1;
          addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + 7'h01;
          array_wr_pend <= 1'b1;
        end
        default: state <= SEP_IGNORE;
      endcase
    end else if (selected && sclk_rise && bitcnt != 3'h0 && state == SEP_WRITE) begin
      // Partial byte after last full one cancels the write
      array_wr_pend <= 1'b0;
    end
  end

  // Output shift: change on falling clock edges
  logic [2:0] txcnt;
  logic sdo, sdo_oe;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      txcnt <= 3'h0;
    end else if (!selected) begin
      sdo_oe <= 1'b0;
      txcnt <= 3'h0;
    end else if (sclk_fall && (state == SEP_READ || state == SEP_STATUS_RD)
                 && bitcnt == 3'h0) begin
      sdo <= tx[7 - txcnt];
      sdo_oe <= 1'b1;
      txcnt <= txcnt + 3'h1;
    end else if (sclk_fall && sdo_oe) begin
      sdo <= tx[7 - txcnt];
      txcnt <= txcnt + 3'h1;
    end
  end
  assign sdo_o = sdo;
  assign sdo_oe_o = sdo_oe;

  // Self-timed write cycle and nonvolatile state
  logic start_sr;
  logic start_arr;
  logic start_wr;
  logic [15:0] page_base;
  logic wp_at_start;
  assign start_sr = cs_rise & status_wr_pend & !hw_prot;
  assign start_arr = cs_rise & array_wr_pend & (bitcnt == 3'h0);
  assign start_wr = (start_sr | start_arr) & ~busy;
  assign page_base = {addr[15:PAGE_BITS], {PAGE_BITS{1'b0}}};

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      wcnt <= 32'h0;
      wr_sr_cycle <= 1'b0;
      wel <= 1'b0;
      ppen <= RST_PPEN;
      bp <= RST_BP;
      wp_at_start <= 1'b0;
    end else if (busy) begin
      if (wcnt == 32'(WRITE_CYCLES - 1)) begin
        busy <= 1'b0;
        wel <= 1'b0;
        if (wr_sr_cycle) begin
          bp <= status_wr_val[ST_BP_HI:ST_BP_LO];
          // Pin level taken at start: a pin change mid-cycle has no effect
          ppen <= (ppen & wp_at_start) | status_wr_val[ST_PPEN];
        end else begin
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld[i] && !addr_protected(page_base | 16'(i), bp)) begin
              mem[page_base | 16'(i)] <= page_buf[i];
            end
          end
        end
      end else begin
        wcnt <= wcnt + 32'h1;
      end
    end else if (start_wr) begin
      busy <= 1'b1;
      wcnt <= 32'h0;
      wr_sr_cycle <= start_sr;
      wp_at_start <= wp_low;
    end else if (byte_done && state == SEP_OPCODE) begin
      if ((rx_byte & OP_MASK) == OP_SET_WEL) begin
        wel <= 1'b1;
      end else if ((rx_byte & OP_MASK) == OP_CLR_WEL) begin
        wel <= 1'b0;
      end
    end
  end

  // Observation outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
      write_latch_o <= 1'b0;
    end else begin
      busy_o <= busy;
      write_latch_o <= wel;
    end
  end
endmodule // sep_core

/* testbench/sep_core_asserts.sv */
// Port assertions for the EEPROM command core
`timescale 1ns/1ps
module sep_core_asserts #(
  parameter int WRITE_CYCLES = 20
) (
  // Clock, reset and pins
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic busy_o,
  input wire logic write_latch_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  int busy_cnt;
  // Busy length, too long for a repetition
  always_ff @(posedge core_clk_i) begin
    if (!busy_o)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  property p_oe_idle; cs_b_i [*6] |-> !sdo_oe_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
  property p_oe_sel; $rose(sdo_oe_o) |-> !cs_b_i && !sclk_i; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("sdo enabled off a falling edge");
  property p_sdo_fall; sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> !sclk_i; endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo changed in clock high");
  property p_busy_start; $rose(busy_o) |-> cs_b_i && write_latch_o; endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle bad start");
  property p_busy_hold; $rose(busy_o) |=> busy_o [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_busy_len; $fell(busy_o) |-> busy_cnt inside {[WRITE_CYCLES-2:WRITE_CYCLES+2]}; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_latch_clear; $fell(busy_o) |-> ##[0:2] !write_latch_o; endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write");
  property p_latch_set; $rose(write_latch_o) |-> !busy_o; endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set during write");
  c_busy: cover property ($rose(busy_o));
  c_oe: cover property ($rose(sdo_oe_o));
  c_latch: cover property ($fell(write_latch_o));
endmodule // sep_core_asserts
bind sep_core sep_core_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .busy_o(busy_o),
  .write_latch_o(write_latch_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));

/* testbench/sep_spi_master.sv */
// Mode 0 serial master model facing the EEPROM core
`timescale 1ns/1ps
module sep_spi_master (
  // Link pins
  output logic sclk_o,
  output logic cs_b_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [7:0] rx;
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Quarter-ns offset per select adds up over back-to-back frames, so some edges still land on a core clock edge
  task automatic sel();
    #500.25 cs_b_o = 1'b0;
    #62.5;
  endtask
  // Deselect in the low phase after the last bit
  task automatic desel();
    #20 cs_b_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
  task automatic xb(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      #62.5 sclk_o = 1'b1;
      rx[i] = sdo_i;
      #62.5 sclk_o = 1'b0;
    end
  endtask
endmodule // sep_spi_master

/* testbench/sep_core_tb_top.sv */
// Self-checking bench for the EEPROM command core
`timescale 1ns/1ps
module sep_core_tb_top;
  import sep_pkg::*;
  localparam int WC = 400;
  logic core_clk, rst_b, wp_b, sclk, cs_b, sdi, sdo, sdo_oe, busy, wl;
  wire sdo_w = sdo_oe ? sdo : 1'bz;
  logic [7:0] mem [65536];
  logic [7:0] exp_q[$];
  logic [7:0] seen;
  logic [7:0] v[5];
  logic [15:0] ta[6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
  logic [15:0] ps[4] = '{16'h0000, PROT_QUARTER, PROT_HALF, PROT_ALL};
  string what;
  int mismatches, tests_run;
  event got;
  sep_core #(.WRITE_CYCLES(WC)) u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .sclk_i(sclk), .cs_b_i(cs_b), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .wp_b_i(wp_b), .busy_o(busy), .write_latch_o(wl));
  sep_spi_master u_m (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo_w));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic test_done();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic note(input logic [7:0] e, input logic [7:0] s, input string n);
    exp_q.push_back(e);
    seen = s;
    what = n;
    -> got;
    #1;
  endtask
  always @(got) check(seen, exp_q.pop_front());
  task automatic cmd(input logic [7:0] op);
    u_m.sel();
    u_m.xb(op);
    u_m.desel();
  endtask
  task automatic st(input logic [7:0] e);
    u_m.sel();
    u_m.xb(8'h05);
    u_m.xb(8'h00);
    u_m.desel();
    note(e, u_m.rx, "status");
    repeat (4) @(negedge core_clk);
    note(8'h00, {7'h0, sdo_oe}, "output enable");
  endtask
  // First byte must still fall inside the write cycle
  task automatic poll();
    u_m.sel();
    u_m.xb(8'h05);
    u_m.xb(8'h00);
    note(8'hff, u_m.rx, "busy status");
    note(8'h01, {7'h0, busy}, "busy pin");
    for (int i = 0; i < 40 && u_m.rx[0] !== 1'b0; i++)
      u_m.xb(8'h00);
    u_m.desel();
    note(8'h00, {6'h0, wl, u_m.rx[0]}, "ready and latch");
  endtask
  task automatic wf(input logic [7:0] pre, input logic [7:0] op, input int n, input logic pl);
    cmd(pre);
    u_m.sel();
    u_m.xb(op);
    for (int i = 0; i < n; i++)
      u_m.xb(v[i]);
    u_m.desel();
    if (pl)
      poll();
  endtask
  // Bit 3 set in the opcode; input noise after the address
  task automatic rd(input logic [15:0] a, input int n);
    u_m.sel();
    u_m.xb(8'h0b);
    u_m.xb(a[15:8]);
    u_m.xb(a[7:0]);
    for (int i = 0; i < n; i++) begin
      u_m.xb(8'($urandom));
      note(mem[16'(a + i)], u_m.rx, "read data");
    end
    u_m.desel();
  endtask
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_b = 1'b0;
    wp_b = 1'b1;
    void'($urandom(32'h3ede));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(8'h00);
    cmd(8'h0e);
    st(8'h02);
    cmd(8'h04);
    st(8'h00);
    $display("test opcodes done");
    for (int lv = 0; lv < 4; lv++) begin
      v[0] = {4'h0, 2'(lv), 2'h0};
      // Pin enable is clear here, so a random pin level must not matter
      @(posedge core_clk) wp_b <= 1'($urandom);
      wf(8'h06, 8'h01, 1, 1);
      st(v[0]);
      foreach (ta[j]) begin
        v = '{ta[j][15:8], ta[j][7:0], 8'($urandom), 8'h00, 8'h00};
        wf(8'h06, 8'h02, 3, 1);
        if (lv == 0 || ta[j] < ps[lv])
          mem[ta[j]] = v[2];
        rd(ta[j], 1);
      end
    end
    @(posedge core_clk) wp_b <= 1'b1;
    $display("test protect levels done");
    v[0] = 8'h8c;
    wf(8'h06, 8'h01, 1, 1);
    @(posedge core_clk) wp_b <= 1'b0;
    v[0] = 8'h00;
    wf(8'h06, 8'h01, 1, 0);
    st(8'h8e);
    @(posedge core_clk) wp_b <= 1'b1;
    wf(8'h06, 8'h01, 1, 1);
    st(8'h00);
    $display("test pin protect done");
    v = '{8'h1f, 8'h7e, 8'($urandom), 8'($urandom), 8'($urandom)};
    wf(8'h06, 8'h02, 5, 1);
    mem[16'h1f7e] = v[2];
    mem[16'h1f7f] = v[3];
    mem[16'h1f00] = v[4];
    rd(16'h1f7e, 2);
    v[1] = 8'h00;
    v[2] = ~v[4];
    wf(8'h04, 8'h02, 3, 0);
    rd(16'h1f00, 1);
    rd(16'hffff, 2);
    $display("test page and wrap done");
    test_done();
  end
  initial begin
    // About half a millisecond of frames expected; limit well above it
    #750000;
    mismatches++;
    test_done();
  end
endmodule // sep_core_tb_top
